// [bench/scdb_host_model.sv]
// Host configuration master model driving strobes at the falling edge
`timescale 1ns/100ps
module scdb_host_model (
   input  wire logic        ref_clk_i,   // Clock
   output logic             cfg_wr_o,    // Write strobe
   output logic             cfg_rd_o,    // Read strobe
   output logic [2:0]       cfg_func_o,  // Function number
   output logic [7:0]       cfg_addr_o,  // Dword offset
   output logic [3:0]       cfg_be_o,    // Byte enables
   output logic [31:0]      cfg_wdata_o, // Write data
   input  wire logic [31:0] cfg_rdata_i  // Read data
);
   // Quiet bus at time zero
   initial begin
      {cfg_wr_o, cfg_rd_o, cfg_func_o, cfg_addr_o, cfg_be_o} = '0;
      cfg_wdata_o = 32'h5a5a_5a5a;
   end
   // One-cycle write; callers write shared bits on function 0, and once on function 1 to check the refusal
   task automatic wr(input logic [2:0] f, input logic [7:0] a, input logic [31:0] d);
      @(negedge ref_clk_i);
      {cfg_func_o, cfg_addr_o, cfg_be_o, cfg_wdata_o} = {f, a, 4'hf, d};
      cfg_wr_o = 1'b1;
      @(negedge ref_clk_i);
      cfg_wr_o = 1'b0;
      cfg_wdata_o = ~d; // Released data never shows the last value
   endtask
   // One-cycle read; data is taken in the cycle after the read edge
   task automatic rd(input logic [2:0] f, input logic [7:0] a, output logic [31:0] d);
      @(negedge ref_clk_i);
      {cfg_func_o, cfg_addr_o, cfg_be_o} = {f, a, 4'hf};
      cfg_rd_o = 1'b1;
      @(negedge ref_clk_i);
      cfg_rd_o = 1'b0;
      d = cfg_rdata_i;
   endtask
endmodule

// [bench/testbench.sv]
// Self-checking bench for the system control and debounce block
`timescale 1ns/100ps
`define CHECK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module testbench;
   import scdb_pkg::*;
   logic ref_clk_i = 1'b0, nrst_i = 1'b0, supply = 1'b0, par_err = 1'b0;
   logic pme = 1'b0, ring = 1'b0, ring_en = 1'b0, cd_n = 1'b1;
   logic cfg_wr, cfg_rd, serr_n, serr_oe, clk_hold, pm_ring, pm_ring_oe, cd_out;
   logic [2:0]  cfg_func;
   logic [7:0]  cfg_addr;
   logic [3:0]  cfg_be;
   logic [31:0] cfg_wdata, rdata, rd;
   int          failures = 0, cmp_count = 0;
   // 20 MHz clock
   always #25 ref_clk_i = ~ref_clk_i;
   scdb_host_model u_host (.ref_clk_i(ref_clk_i), .cfg_wr_o(cfg_wr), .cfg_rd_o(cfg_rd), .cfg_func_o(cfg_func),
      .cfg_addr_o(cfg_addr), .cfg_be_o(cfg_be), .cfg_wdata_o(cfg_wdata), .cfg_rdata_i(rdata));
   scdb_top u_scdb_top (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .cfg_wr_i(cfg_wr), .cfg_rd_i(cfg_rd),
      .cfg_func_i(cfg_func), .cfg_addr_i(cfg_addr), .cfg_be_i(cfg_be), .cfg_wdata_i(cfg_wdata),
      .cfg_rdata_o(rdata), .legacy_supply_sel_i(supply), .card_par_err_i(par_err), .pme_i(pme),
      .ring_indicate_out_i(ring), .ring_indicate_en_i(ring_en), .media_card_detect_n_i(cd_n),
      .serr_n_o(serr_n), .serr_oe_o(serr_oe), .clk_hold_o(clk_hold), .pm_ring_o(pm_ring),
      .pm_ring_oe_o(pm_ring_oe), .media_card_detect_n_o(cd_out));
   // Single exit point of the run
   task print_verdict;
      $display("Mismatches %0d, comparisons %0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Defaults right after global reset
   task t_reset_values;
      u_host.rd(3'h0, 8'h84, rd);
      `CHECK(rd, 32'h19)
      u_host.rd(3'h0, 8'h80, rd);
      `CHECK(rd, 32'h0)
      `CHECK({clk_hold, pm_ring_oe, serr_oe}, 3'h0)
   endtask
   // All ones written: reserved bit stays zero, supply bit follows pin
   task t_sysctl;
      u_host.wr(3'h0, 8'h80, 32'hffff_ffff);
      u_host.rd(3'h0, 8'h80, rd);
      `CHECK(rd, 32'h13)
      `CHECK(clk_hold, 1'b1)
      supply = 1'b1;
      u_host.rd(3'h0, 8'h80, rd);
      `CHECK(rd, 32'h17)
      supply = 1'b0;
      u_host.wr(3'h0, 8'h80, 32'h0);
      `CHECK(clk_hold, 1'b0)
      u_host.wr(3'h1, 8'h80, 32'h1f);
      `CHECK(clk_hold, 1'b0)
      u_host.rd(3'h1, 8'h80, rd);
      `CHECK(rd, 32'h0)
   endtask
   // Parity error escalates only while enabled
   task t_parity;
      u_host.wr(3'h0, 8'h80, 32'h10);
      par_err = 1'b1;
      @(negedge ref_clk_i);
      `CHECK({serr_oe, serr_n}, 2'b10)
      u_host.wr(3'h0, 8'h80, 32'h0);
      @(negedge ref_clk_i);
      `CHECK(serr_oe, 1'b0)
      par_err = 1'b0;
   endtask
   // Every select and enable combination on the shared pin
   task t_pin;
      for (int i = 0; i < 8; i++) begin
         u_host.wr(3'h0, 8'h80, {31'h0, i[0]});
         ring_en = i[1];
         pme = i[2];
         ring = ~i[2];
         #1;
         `CHECK(pm_ring_oe, i[0] | i[1])
         if (i[0] | i[1]) `CHECK(pm_ring, i[0] ? i[2] : ~i[2])
      end
      ring_en = 1'b0;
   endtask
   // Zero count is immediate; one step measured from the last toggle
   task t_debounce;
      int n;
      u_host.wr(3'h1, 8'h84, 32'h0);
      cd_n = 1'b0;
      repeat (6) @(negedge ref_clk_i);
      `CHECK(cd_out, 1'b0)
      u_host.wr(3'h1, 8'h84, 32'h1);
      u_host.rd(3'h0, 8'h84, rd);
      `CHECK(rd, 32'h1)
      u_host.rd(3'h1, 8'h84, rd);
      `CHECK(rd, 32'h1)
      cd_n = 1'b1;
      repeat (1000) @(negedge ref_clk_i);
      cd_n = 1'b0;
      repeat (100) @(negedge ref_clk_i);
      `CHECK(cd_out, 1'b0)
      cd_n = 1'b1;
      n = 0;
      while (cd_out !== 1'b1 && n < 45000) begin
         @(negedge ref_clk_i);
         n++;
      end
      `CHECK(n >= 40000 && n <= 40010, 1'b1)
   endtask
   // Main sequence; a second global reset restores every default
   initial begin
      repeat (2) @(negedge ref_clk_i);
      nrst_i = 1'b1;
      t_reset_values();
      t_sysctl();
      t_parity();
      t_pin();
      t_debounce();
      nrst_i = 1'b0;
      repeat (2) @(negedge ref_clk_i);
      nrst_i = 1'b1;
      t_reset_values();
      print_verdict();
   end
   // Watchdog: about 60000 cycles, well beyond one debounce step
   initial begin
      #3_000_000;
      failures++;
      print_verdict();
   end
endmodule

// [logic/scdb_pkg.sv]
// Package: offsets, fields, reset values and timing counts of the system control and debounce block
package scdb_pkg;
   // Configuration offsets
   localparam logic [7:0]  SYSCTL_OFFSET      = 8'h80;
   localparam logic [7:0]  DEBOUNCE_OFFSET    = 8'h84;
   // System control low field positions
   localparam int          OUT_SEL_BIT        = 0;
   localparam int          KEEPALIVE_BIT      = 1;
   localparam int          SUPPLY_BIT         = 2;
   localparam int          RSVD3_BIT          = 3;
   localparam int          PARITY_BIT         = 4;
   // Reset values
   localparam logic [7:0]  DEBOUNCE_RESET     = 8'h19;
   localparam logic        KEEPALIVE_RESET    = 1'b0;
   localparam logic        PARITY_RESET       = 1'b0;
   localparam logic        OUT_SEL_RESET      = 1'b0;
   // Timing: one debounce step
   localparam int          CLK_HZ             = 20_000_000;
   localparam int          STEP_MS            = 2;
   localparam int          STEP_CYCLES        = CLK_HZ / 1000 * STEP_MS;
   localparam int          STEP_CNT_W         = 16;
endpackage

// [logic/scdb_step_if.sv]
// Interface: debounce step tick between step timer and main logic
`timescale 1ns/100ps
interface scdb_step_if;
   logic tick;
   logic clear;
   modport timer (output tick, input clear);
   modport user  (input tick, output clear);
endinterface

// [logic/scdb_step_timer.sv]
// Step timer: pulses once per debounce step, restartable
`timescale 1ns/100ps
module scdb_step_timer
   import scdb_pkg::*;
#(
   parameter logic [STEP_CNT_W-1:0] STEP_LEN = STEP_CNT_W'(STEP_CYCLES)
) (
   input  wire logic      ref_clk_i,   // Clock
   input  wire logic      nrst_i,      // Global reset, active low
   scdb_step_if.timer     step         // Tick and restart
);
   typedef struct packed {
      logic [STEP_CNT_W-1:0] cnt;
      logic                  tick;
   } scdb_tmr_t;
   scdb_tmr_t st, next_st;

   // Count down one step; restart on clear
   always_comb begin
      next_st = st;
      next_st.tick = 1'b0;
      if (step.clear || st.cnt == '0) begin
         next_st.cnt = STEP_LEN - 1'b1;
         next_st.tick = !step.clear && st.cnt == '0;
      end else begin
         next_st.cnt = st.cnt - 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign step.tick = st.tick;
endmodule

// [logic/scdb_top.sv]
// Top: system control low bits, card detect debounce register and debouncer
`timescale 1ns/100ps
// How it works
// - Parity escalation bit routes card parity to SERR
// - Bit three of the control word always reads zero
// - Supply indication reads 0 3.3V, 1 5V
// - Keep-alive bit holds both clocks running
// - Select bit set drives PME out
// - Select clear, ring enable drives ring out
// - Both clear: shared pin floats
// - Control bits cleared only by global reset
// - Debounce register counts 2 ms steps
// - Debounce resets to 19h, 50 ms
// - Debounce cleared only by global reset
// - Debounce at 84h in functions 0, 1
module scdb_top
   import scdb_pkg::*;
(
   input  wire logic        ref_clk_i,          // Clock, 20 MHz
   input  wire logic        nrst_i,             // Global reset, active low
   input  wire logic        cfg_wr_i,           // Config write strobe
   input  wire logic        cfg_rd_i,           // Config read strobe
   input  wire logic [2:0]  cfg_func_i,         // Config function number
   input  wire logic [7:0]  cfg_addr_i,         // Config dword offset
   input  wire logic [3:0]  cfg_be_i,           // Byte enables
   input  wire logic [31:0] cfg_wdata_i,        // Write data
   output logic      [31:0] cfg_rdata_o,        // Read data, registered
   input  wire logic        legacy_supply_sel_i,// 5 V supply selected
   input  wire logic        card_par_err_i,     // Card bus data parity error
   input  wire logic        pme_i,              // PME source
   input  wire logic        ring_indicate_out_i,// Ring indicate source
   input  wire logic        ring_indicate_en_i, // Ring enable from card control
   input  wire logic        media_card_detect_n_i, // Raw card detect
   output logic             serr_n_o,           // SERR drive, active low
   output logic             serr_oe_o,          // SERR output enable
   output logic             clk_hold_o,         // Keep system and card clocks
   output logic             pm_ring_o,          // Shared pin level
   output logic             pm_ring_oe_o,       // Shared pin enable
   output logic             media_card_detect_n_o // Debounced card detect
);
   typedef struct packed {
      logic       parity_to_syserr_en;
      logic       clock_keepalive;
      logic       pm_ring_out_sel;
      logic [7:0] card_detect_debounce;
      logic [7:0] stable_cnt;
      logic       cd_sync1;
      logic       cd_sync2;
      logic       cd_seen;
      logic       cd_out;
      logic       serr;
      logic [31:0] rdata;
   } scdb_st_t;
   scdb_st_t st, next_st;

   scdb_step_if step ();

   scdb_step_timer u_timer (
      .ref_clk_i (ref_clk_i),
      .nrst_i    (nrst_i),
      .step      (step)
   );

   // Toggle restarts step timer so stability counts whole steps
   assign step.clear = st.cd_sync2 != st.cd_seen;

   logic f0_hit, f01_hit;
   assign f0_hit  = cfg_func_i == 3'h0;
   assign f01_hit = cfg_func_i <= 3'h1;

   always_comb begin
      next_st = st;
      // Card detect is asynchronous; only the second stage is read further on
      next_st.cd_sync1 = media_card_detect_n_i;
      next_st.cd_sync2 = st.cd_sync1;
      next_st.serr = st.parity_to_syserr_en && card_par_err_i;
      // Global bits live only in function 0
      if (cfg_wr_i && f0_hit && cfg_addr_i == SYSCTL_OFFSET && cfg_be_i[0]) begin
         next_st.parity_to_syserr_en = cfg_wdata_i[PARITY_BIT];
         next_st.clock_keepalive     = cfg_wdata_i[KEEPALIVE_BIT];
         next_st.pm_ring_out_sel     = cfg_wdata_i[OUT_SEL_BIT];
      end
      if (cfg_wr_i && f01_hit && cfg_addr_i == DEBOUNCE_OFFSET && cfg_be_i[0]) begin
         next_st.card_detect_debounce = cfg_wdata_i[7:0];
      end
      // Read mux; unmapped offsets read zero
      next_st.rdata = '0;
      if (cfg_rd_i && f0_hit && cfg_addr_i == SYSCTL_OFFSET) begin
         next_st.rdata[PARITY_BIT]    = st.parity_to_syserr_en;
         next_st.rdata[RSVD3_BIT]     = 1'b0;
         next_st.rdata[SUPPLY_BIT]    = legacy_supply_sel_i;
         next_st.rdata[KEEPALIVE_BIT] = st.clock_keepalive;
         next_st.rdata[OUT_SEL_BIT]   = st.pm_ring_out_sel;
      end else if (cfg_rd_i && f01_hit && cfg_addr_i == DEBOUNCE_OFFSET) begin
         next_st.rdata[7:0] = st.card_detect_debounce;
      end
      // Debounce: count steps while stable, restart on toggle
      if (st.cd_sync2 != st.cd_seen) begin
         next_st.cd_seen    = st.cd_sync2;
         next_st.stable_cnt = '0;
      end else if (step.tick && st.cd_out != st.cd_seen) begin
         next_st.stable_cnt = st.stable_cnt + 8'h01;
         if (st.stable_cnt + 8'h01 >= st.card_detect_debounce) begin
            next_st.cd_out = st.cd_seen;
         end
      end else if (st.cd_out != st.cd_seen && st.card_detect_debounce == 8'h00) begin
         next_st.cd_out = st.cd_seen; // Zero interval passes at once
      end
   end

   // Only the global reset clears these; bus reset is not a port here
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         st                      <= '0;
         st.parity_to_syserr_en  <= PARITY_RESET;
         st.clock_keepalive      <= KEEPALIVE_RESET;
         st.pm_ring_out_sel      <= OUT_SEL_RESET;
         st.card_detect_debounce <= DEBOUNCE_RESET;
         st.cd_sync1             <= 1'b1; // Idle level, so no false edge after reset
         st.cd_sync2             <= 1'b1;
         st.cd_seen              <= 1'b1;
         st.cd_out               <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // Outputs
   assign cfg_rdata_o           = st.rdata;
   assign serr_n_o              = 1'b0;
   assign serr_oe_o             = st.serr;
   assign clk_hold_o            = st.clock_keepalive;
   assign pm_ring_o             = st.pm_ring_out_sel ? pme_i : ring_indicate_out_i;
   assign pm_ring_oe_o          = st.pm_ring_out_sel || ring_indicate_en_i;
   assign media_card_detect_n_o = st.cd_out;

   // Error seen while enabled shows on SERR one cycle later
   a_parity_serr: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      st.parity_to_syserr_en && card_par_err_i |=> serr_oe_o)
      else $error("parity not escalated");
   // Disabled escalation never drives SERR
   a_parity_quiet: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      !st.parity_to_syserr_en |=> !serr_oe_o)
      else $error("parity escalated while off");
   // No error, no SERR, whatever the enable
   a_serr_idle: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      !card_par_err_i |=> !serr_oe_o)
      else $error("serr without error");
   // Reserved bit of the control word reads zero; debounce reads may set it
   a_rsvd_zero: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      cfg_rd_i && f0_hit && cfg_addr_i == SYSCTL_OFFSET |=> !cfg_rdata_o[RSVD3_BIT])
      else $error("reserved bit read one");
   // Supply indication is the pin level at the read edge
   a_supply_read: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      cfg_rd_i && f0_hit && cfg_addr_i == SYSCTL_OFFSET |=> cfg_rdata_o[SUPPLY_BIT] == $past(legacy_supply_sel_i))
      else $error("supply bit wrong");
   // Keep-alive output takes the written bit
   a_keep_clock: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      cfg_wr_i && f0_hit && cfg_addr_i == SYSCTL_OFFSET && cfg_be_i[0] |=> clk_hold_o == $past(cfg_wdata_i[KEEPALIVE_BIT]))
      else $error("keepalive mismatch");
   // Nothing but a write or the global reset moves keep-alive
   a_keep_hold: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      !(cfg_wr_i && f0_hit && cfg_addr_i == SYSCTL_OFFSET && cfg_be_i[0]) |=> $stable(clk_hold_o))
      else $error("keepalive moved");
   // Parity and select bits ignore writes from other functions
   a_func1_refused: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      cfg_wr_i && !f0_hit && cfg_addr_i == SYSCTL_OFFSET |=> $stable(st.parity_to_syserr_en) && $stable(st.pm_ring_out_sel))
      else $error("shared bit written from other function");
   // Select set: PME on the shared pin
   a_pme_route: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      st.pm_ring_out_sel |-> pm_ring_oe_o && pm_ring_o == pme_i)
      else $error("pme not routed");
   // Select clear, ring enabled: ring indicate on the shared pin
   a_ring_route: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      !st.pm_ring_out_sel && ring_indicate_en_i |-> pm_ring_oe_o && pm_ring_o == ring_indicate_out_i)
      else $error("ring not routed");
   // Both clear: shared pin released
   a_pin_float: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      !st.pm_ring_out_sel && !ring_indicate_en_i |-> !pm_ring_oe_o)
      else $error("pin driven");
   // Global reset loads the default interval
   a_deb_reset: assert property (
      @(posedge ref_clk_i)
      !nrst_i |=> st.card_detect_debounce == DEBOUNCE_RESET)
      else $error("debounce reset wrong");
   // Second function reaches the same interval register
   a_deb_write: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      cfg_wr_i && cfg_func_i == 3'h1 && cfg_addr_i == DEBOUNCE_OFFSET && cfg_be_i[0]
      |=> st.card_detect_debounce == $past(cfg_wdata_i[7:0]))
      else $error("func1 write lost");
   // Second function reads the interval back
   a_deb_read: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      cfg_rd_i && cfg_func_i == 3'h1 && cfg_addr_i == DEBOUNCE_OFFSET
      |=> cfg_rdata_o[7:0] == $past(st.card_detect_debounce))
      else $error("func1 read wrong");
   // Interval keeps its value unless written
   a_deb_hold: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      !(cfg_wr_i && f01_hit && cfg_addr_i == DEBOUNCE_OFFSET && cfg_be_i[0]) |=> $stable(st.card_detect_debounce))
      else $error("debounce moved");
   // Each whole stable step adds one to the count
   a_cd_count: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      step.tick && st.cd_out != st.cd_seen && st.cd_sync2 == st.cd_seen |=> st.stable_cnt == $past(st.stable_cnt) + 8'h01)
      else $error("step not counted");
   // A toggle restarts the count and holds the output
   a_cd_restart: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      st.cd_sync2 != st.cd_seen |=> st.stable_cnt == 8'h00 && $stable(media_card_detect_n_o))
      else $error("toggle did not restart");
   // Output only ever takes the level the input held
   a_cd_stable: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      $changed(media_card_detect_n_o) |-> media_card_detect_n_o == $past(st.cd_sync2))
      else $error("unstable accept");
endmodule
